/* rgb_pkg.sv */
// Shared constants and types for the double-data-rate link bridge
package rgb_pkg;
	localparam int CLK_NS = 25;
	localparam int LINK_NS_1000 = 8;
	localparam int LINK_NS_100 = 40;
	localparam int LINK_NS_10 = 400;
	localparam int PHY_RST_NS = 1000;

	// Half link period in system cycles, never below one
	function automatic int half_cyc(input int ns);
		int c;
		c = ns / (2 * CLK_NS);
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [7:0] TX_HALF_1000 = 8'(half_cyc(LINK_NS_1000));
	localparam logic [7:0] TX_HALF_100 = 8'(half_cyc(LINK_NS_100));
	localparam logic [7:0] TX_HALF_10 = 8'(half_cyc(LINK_NS_10));
	localparam logic [7:0] PHY_RST_CYC = 8'((PHY_RST_NS + CLK_NS - 1) / CLK_NS);

	// In-band link status codes carried on rx data bits 2:1 while idle
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	localparam logic [1:0] SPD_RST = SPD_1000;

	// Pin vector layout
	localparam int PIN_N = 12;
	localparam int PIN_TXD = 0;
	localparam int PIN_TXC = 4;
	localparam int PIN_TXCTL = 5;
	localparam int PIN_RXC = 6;
	localparam int PIN_RXCTL = 7;
	localparam int PIN_RXD = 8;
	localparam logic [11:0] TX_PIN_MASK = 12'h03F;

	localparam int FIFO_DEPTH = 8;

	typedef struct packed {
		logic [7:0] data;
		logic       dv;
		logic       er;
	} rgb_word_s;

	typedef enum logic {TXS_RISE, TXS_FALL} rgb_tx_e;
endpackage

/* rgb_bridge.sv */
// Receive buffer and double-data-rate to single-data-rate bridge top
`timescale 1ns/1ps

module rgb_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	wire          full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
	wire          empty = (wr_r == rd_r);
	wire          do_wr = in_valid && !full;
	wire          do_rd = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_r[rd_r[AW-1:0]];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (do_wr)
				wr_r <= wr_r + 1'b1;
			if (do_rd)
				rd_r <= rd_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (do_wr)
			mem_r[wr_r[AW-1:0]] <= in_data;
	end
endmodule // rgb_fifo

module rgb_bridge #(
	parameter int TILE_ID = 1
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              rgmii_en,
	input  wire logic              tx_clk_delay,
	input  wire logic [11:0]       pin_i,
	output logic [11:0]            pin_o,
	output logic [11:0]            pin_oe,
	input  wire logic [11:0]       gpio_o,
	input  wire logic [11:0]       gpio_oe,
	input  wire rgb_pkg::rgb_word_s tx_word,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	output rgb_pkg::rgb_word_s     rx_word,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic                   rx_drop,
	output logic [1:0]             link_speed,
	output logic                   phy_rst_b,
	input  wire logic              mdc_low,
	input  wire logic              mdio_low,
	input  wire logic              mdio_i,
	output logic                   mdc_o,
	output logic                   mdc_oe,
	output logic                   mdio_o,
	output logic                   mdio_oe,
	output logic                   smi_data_in
);
	// Receive pins and the management data line cross into clk
	logic [6:0] s1_r;
	logic [6:0] s2_r;
	logic [6:0] s3_r;
	logic [6:0] st_r;
	logic       rxc_prev_r;
	wire  [6:0] raw = {mdio_i, pin_i[rgb_pkg::PIN_RXD +: 4], pin_i[rgb_pkg::PIN_RXCTL],
		pin_i[rgb_pkg::PIN_RXC]};
	wire  [6:0] agree = ~(s2_r ^ s3_r);
	wire  [6:0] st_nxt = (agree & s3_r) | (~agree & st_r);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			st_r <= '0;
			rxc_prev_r <= 1'b0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			st_r <= st_nxt;
			rxc_prev_r <= st_r[0];
		end
	end

	wire       rx_clk_s = st_r[0];
	wire       rx_ctl_s = st_r[1];
	wire [3:0] rxd_s = st_r[5:2];
	wire       rx_rise = rx_clk_s && !rxc_prev_r;
	wire       rx_fall = !rx_clk_s && rxc_prev_r;
	assign smi_data_in = st_r[6];

	// Receive: low nibble and valid on rising, high nibble and xor on falling
	logic [3:0] rx_lo_r;
	logic       rx_dv_r;
	logic [1:0] speed_r;
	logic       drop_r;
	wire        rx_push = rgmii_en && rx_fall && rx_dv_r;
	wire        fifo_in_ready;
	rgb_pkg::rgb_word_s rx_in;
	assign rx_in.data = {rxd_s, rx_lo_r};
	assign rx_in.dv = rx_dv_r;
	assign rx_in.er = rx_dv_r ^ rx_ctl_s;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_lo_r <= 4'h0;
			rx_dv_r <= 1'b0;
			speed_r <= rgb_pkg::SPD_RST;
			drop_r <= 1'b0;
		end else begin
			if (rx_rise) begin
				rx_lo_r <= rxd_s;
				rx_dv_r <= rx_ctl_s;
			end
			// Status only means anything between frames
			if (rx_rise && !rx_ctl_s && rgmii_en)
				speed_r <= rxd_s[2:1];
			drop_r <= rx_push && !fifo_in_ready;
		end
	end
	assign link_speed = speed_r;
	assign rx_drop = drop_r;

	// The PHY cannot stall, so a full buffer drops the byte and pulses rx_drop
	rgb_fifo #(
		.W     ($bits(rgb_pkg::rgb_word_s)),
		.DEPTH (rgb_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_data   (rx_in),
		.in_valid  (rx_push),
		.in_ready  (fifo_in_ready),
		.out_data  (rx_word),
		.out_valid (rx_valid),
		.out_ready (rx_ready && rgmii_en)
	);

	// Transmit clock made by dividing clk; half period follows link speed
	wire [7:0] tx_half = (speed_r == rgb_pkg::SPD_10) ? rgb_pkg::TX_HALF_10 :
		(speed_r == rgb_pkg::SPD_100) ? rgb_pkg::TX_HALF_100 : rgb_pkg::TX_HALF_1000;
	rgb_pkg::rgb_tx_e   tx_st_r;
	rgb_pkg::rgb_word_s tx_byte_r;
	logic [7:0] tx_cnt_r;
	logic       txc_r;
	logic       txc_dly_r;
	logic [3:0] txd_r;
	logic       txctl_r;
	wire        tx_edge = (tx_cnt_r == 8'h00);
	wire        tx_take = tx_edge && (tx_st_r == rgb_pkg::TXS_FALL);
	wire        tx_go = tx_valid && rgmii_en;
	wire rgb_pkg::rgb_word_s tx_next = tx_go ? tx_word : '0;

	assign tx_ready = tx_take && rgmii_en;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r <= rgb_pkg::TXS_FALL;
			tx_byte_r <= '0;
			tx_cnt_r <= 8'h00;
			txc_r <= 1'b0;
			txd_r <= 4'h0;
			txctl_r <= 1'b0;
		end else begin
			tx_cnt_r <= tx_edge ? tx_half - 8'h01 : tx_cnt_r - 8'h01;
			if (tx_edge) begin
				case (tx_st_r)
					rgb_pkg::TXS_FALL: begin
						tx_st_r <= rgb_pkg::TXS_RISE;
						tx_byte_r <= tx_next;
						txc_r <= 1'b1;
						txd_r <= tx_next.data[3:0];
						txctl_r <= tx_next.dv;
					end
					rgb_pkg::TXS_RISE: begin
						tx_st_r <= rgb_pkg::TXS_FALL;
						txc_r <= 1'b0;
						txd_r <= tx_byte_r.data[7:4];
						txctl_r <= tx_byte_r.dv ^ tx_byte_r.er;
					end
					default: tx_st_r <= rgb_pkg::TXS_FALL;
				endcase
			end
		end
	end

	// Delayed copy of the transmit clock, one clk later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			txc_dly_r <= 1'b0;
		else
			txc_dly_r <= txc_r;
	end
	wire txc_out = tx_clk_delay ? txc_dly_r : txc_r;

	// Pin ownership: the enable hands the dedicated pins to the bridge
	wire [11:0] bridge_o = {6'h00, txctl_r, txc_out, txd_r};
	wire [11:0] bridge_oe = rgb_pkg::TX_PIN_MASK;
	assign pin_o = rgmii_en ? bridge_o : gpio_o;
	assign pin_oe = rgmii_en ? bridge_oe : gpio_oe;

	// PHY is held in reset until we are out of reset and have been enabled for PHY_RST_CYC cycles
	logic [7:0] prst_cnt_r;
	logic       prst_b_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prst_cnt_r <= 8'h00;
			prst_b_r <= 1'b0;
		end else if (rgmii_en && !prst_b_r) begin
			prst_cnt_r <= prst_cnt_r + 8'h01;
			prst_b_r <= (prst_cnt_r == rgb_pkg::PHY_RST_CYC - 8'h01);
		end
	end
	assign phy_rst_b = prst_b_r;

	// Open-drain: only ever pull low, the board pull-ups give the high
	assign mdc_o = 1'b0;
	assign mdio_o = 1'b0;
	assign mdc_oe = mdc_low;
	assign mdio_oe = mdio_low;

	// Each tile carries its own copy of this module with identical wiring
	localparam int TILE = TILE_ID;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	chk_gpio_pass: assert property (!rgmii_en |-> pin_o == gpio_o && pin_oe == gpio_oe)
		else $error("GPIO control lost while bridge disabled");
	chk_pin_override: assert property (rgmii_en |-> pin_oe == rgb_pkg::TX_PIN_MASK)
		else $error("Pin enables not owned by bridge");
	chk_tx_port_own: assert property (tx_ready |-> rgmii_en && tx_st_r == rgb_pkg::TXS_FALL)
		else $error("Transmit accepted while disabled or mid byte");
	chk_tx_low_nibble: assert property (tx_ready && tx_valid
		|=> txc_r && txd_r == $past(tx_word.data[3:0]) && txctl_r == $past(tx_word.dv))
		else $error("Low nibble or valid not on rising phase");
	// The falling phase lands a fixed count after the take: half period plus one
	chk_tx_high_fast: assert property (tx_ready && tx_valid && tx_half == 8'h01
		|-> ##2 (!txc_r && txd_r == $past(tx_word.data[7:4], 2)
		&& txctl_r == ($past(tx_word.dv, 2) ^ $past(tx_word.er, 2))))
		else $error("High nibble or xor control wrong on falling phase");
	chk_tx_high_slow: assert property (tx_ready && tx_valid && tx_half == 8'h08
		|-> ##9 (!txc_r && txd_r == $past(tx_word.data[7:4], 9)
		&& txctl_r == ($past(tx_word.dv, 9) ^ $past(tx_word.er, 9))))
		else $error("High nibble or xor control wrong on slow falling phase");
	chk_tx_delay: assert property (rgmii_en && tx_clk_delay
		|-> pin_o[rgb_pkg::PIN_TXC] == $past(txc_r))
		else $error("Delayed transmit clock not one cycle late");
	chk_speed_cap: assert property (rgmii_en && rx_rise && !rx_ctl_s
		|=> link_speed == $past(rxd_s[2:1]))
		else $error("Speed not taken from idle status");
	chk_rx_split: assert property (rx_push |-> rx_in.dv && rx_in.er == !rx_ctl_s
		&& rx_in.data[3:0] == rx_lo_r)
		else $error("Receive control split wrong");
	chk_phy_release: assert property ($rose(phy_rst_b) |-> $past(rgmii_en)
		&& $past(prst_cnt_r) == rgb_pkg::PHY_RST_CYC - 8'h01)
		else $error("PHY released early");
	chk_smi_od: assert property (!mdc_o && !mdio_o && mdc_oe == mdc_low
		&& mdio_oe == mdio_low)
		else $error("Management line driven high");
endmodule // rgb_bridge

/* rgb_phy_model.sv */
// Behavioural far-side transceiver: drives the receive half of the nibble link
`timescale 1ns/1ps

module rgb_phy_model (
	input  wire logic       phy_rst_b,
	output logic            rxc,
	output logic            rxctl,
	output logic [3:0]      rxd
);
	initial begin
		rxc = 1'b0;
		rxctl = 1'b0;
		rxd = 4'h5;
	end

	// One link cycle of 200 ns; data leads each clock edge by 50 ns
	task automatic cycle(input logic [3:0] lo, input logic [3:0] hi, input logic c0,
		input logic c1);
		while (phy_rst_b !== 1'b1) #100;
		rxd = lo;
		rxctl = c0;
		#50 rxc = 1'b1;
		#50 rxd = hi;
		rxctl = c1;
		#50 rxc = 1'b0;
		// Clock stands low between frames; released lines show a changed level
		#50 rxd = ~hi;
		rxctl = ~c1;
	endtask

	task automatic send(input logic [7:0] d, input logic er);
		cycle(d[3:0], d[7:4], 1'b1, 1'b1 ^ er);
	endtask

	// Idle cycle carrying the link status code on data bits 2:1
	task automatic idle(input logic [1:0] code);
		cycle({1'b0, code, 1'b0}, {1'b0, code, 1'b0}, 1'b0, 1'b0);
	endtask
endmodule // rgb_phy_model

/* rgb_bridge_bench.sv */
// Self-checking bench for the link bridge: pins, transmit, receive, speed, reset, SMI
`timescale 1ns/1ps

module rgb_bridge_bench;
	logic               clk, rst_b, rgmii_en, tx_clk_delay, tx_valid, rx_ready, tx_ready;
	logic               mdc_low, mdio_low, mdio_i, rx_valid, rx_drop, phy_rst_b;
	logic               mdc_o, mdc_oe, mdio_o, mdio_oe, smi_data_in, rxc, rxctl;
	logic [11:0]        pin_i, pin_o, pin_oe, gpio_o, gpio_oe;
	logic [1:0]         link_speed;
	logic [3:0]         rxd, lo_q, txd_q;
	logic               txc_q = 1'b0, dv_q = 1'b0;
	rgb_pkg::rgb_word_s tx_word, rx_word, w;
	rgb_pkg::rgb_word_s txq[$], rxq[$];
	int                 num_errors = 0, n_checks = 0, drops = 0;

	// Wire level: whoever enables wins, else the far side's level
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & {rxd, rxctl, rxc, 6'h00});

	rgb_bridge dut (.clk(clk), .rst_b(rst_b), .rgmii_en(rgmii_en),
		.tx_clk_delay(tx_clk_delay), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
		.gpio_o(gpio_o), .gpio_oe(gpio_oe), .tx_word(tx_word), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_drop(rx_drop), .link_speed(link_speed), .phy_rst_b(phy_rst_b),
		.mdc_low(mdc_low), .mdio_low(mdio_low), .mdio_i(mdio_i), .mdc_o(mdc_o),
		.mdc_oe(mdc_oe), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .smi_data_in(smi_data_in));

	rgb_phy_model phy (.phy_rst_b(phy_rst_b), .rxc(rxc), .rxctl(rxctl), .rxd(rxd));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic err(input string m);
		num_errors++;
		$display("Error at %0t: %s", $time, m);
	endtask

	function automatic bit bad(input bit c);
		n_checks++;
		return c;
	endfunction

	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err("timeout");
		report_and_stop;
	end

	// A byte is taken at the edge after a negedge that shows tx_ready high
	task automatic send_tx(input int n);
		int i;
		for (int k = 0; k < n; k++) begin
			tx_word = {8'($urandom), 1'b1, 1'($urandom)};
			tx_valid = 1'b1;
			for (i = 0; i < 100 && tx_ready !== 1'b1; i++) @(negedge clk);
			if (tx_ready !== 1'b1) begin
				err("tx stall");
				report_and_stop;
			end
			txq.push_back(tx_word);
			@(negedge clk);
		end
		tx_valid = 1'b0;
	endtask

	// Rebuild transmitted bytes from the pins
	always @(negedge clk) begin
		if (pin_o[4] === 1'b1 && !txc_q && rgmii_en) begin
			lo_q = pin_o[3:0];
			dv_q = pin_o[5];
			if (tx_clk_delay && bad(txd_q !== pin_o[3:0])) err("tx clock not delayed");
		end
		if (pin_o[4] === 1'b0 && txc_q && rgmii_en) begin
			if (dv_q && txq.size() == 0) err("tx extra byte");
			else if (dv_q && bad(txq.pop_front() !== {pin_o[3:0], lo_q, 1'b1, dv_q ^ pin_o[5]}))
				err("tx byte");
			dv_q = 1'b0;
		end
		txc_q = pin_o[4];
		txd_q = pin_o[3:0];
	end

	always @(posedge clk) begin
		if (rx_drop === 1'b1) drops++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			if (rxq.size() == 0) err("rx extra word");
			else if (bad(rx_word !== rxq.pop_front())) err("rx word");
		end
	end

	initial begin
		void'($urandom(4361));
		{rst_b, rgmii_en, tx_clk_delay, tx_valid, rx_ready, mdc_low, mdio_low} = 7'h00;
		mdio_i = 1'b1;
		gpio_o = 12'($urandom);
		gpio_oe = 12'($urandom);
		tx_word = '0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		tx_valid = 1'b1;
		repeat (6) @(negedge clk);
		if (bad(pin_o !== gpio_o || pin_oe !== gpio_oe)) err("gpio pins");
		if (bad(tx_ready !== 1'b0 || phy_rst_b !== 1'b0)) err("disabled");
		tx_valid = 1'b0;
		rgmii_en = 1'b1;
		repeat (30) @(negedge clk);
		if (bad(pin_oe !== 12'h03F)) err("enabled pins");
		if (bad(phy_rst_b !== 1'b0)) err("phy reset early");
		repeat (14) @(negedge clk);
		if (bad(phy_rst_b !== 1'b1)) err("phy reset held");
		for (int k = 0; k < 8; k++) begin
			{mdc_low, mdio_low, mdio_i} = 3'($urandom);
			repeat (5) @(negedge clk);
			if (bad({mdc_oe, mdio_oe, mdc_o, mdio_o} !== {mdc_low, mdio_low, 2'h0})) err("smi oe");
			if (bad(smi_data_in !== mdio_i)) err("smi in");
		end
		send_tx(6);
		// Fill the buffer past full with no pops, then drain with random stalls
		for (int k = 0; k < 9; k++) begin
			w = {8'($urandom), 1'b1, 1'($urandom)};
			if (k < 8) rxq.push_back(w);
			phy.send(w.data, w.er);
		end
		@(negedge clk);
		repeat (10) @(negedge clk);
		if (bad(drops !== 1)) err("rx drop");
		for (int k = 0; k < 400 && rxq.size() > 0; k++) begin
			rx_ready = 1'($urandom);
			@(negedge clk);
		end
		rx_ready = 1'b0;
		@(negedge clk);
		if (bad(rxq.size() != 0 || rx_valid !== 1'b0)) err("rx drain");
		for (int s = 1; s < 4; s++) begin
			phy.idle(2'(s % 3));
			@(negedge clk);
			repeat (10) @(negedge clk);
			if (bad(link_speed !== 2'(s % 3))) err("link speed");
		end
		tx_clk_delay = 1'b1;
		send_tx(4);
		repeat (40) @(negedge clk);
		if (bad(txq.size() != 0)) err("tx lost");
		rgmii_en = 1'b0;
		phy.send(8'h5A, 1'b0);
		@(negedge clk);
		repeat (10) @(negedge clk);
		if (bad(rx_valid !== 1'b0)) err("rx while disabled");
		rst_b = 1'b0;
		@(negedge clk);
		if (bad(phy_rst_b !== 1'b0 || link_speed !== 2'h2)) err("second reset");
		rst_b = 1'b1;
		report_and_stop;
	end
endmodule // rgb_bridge_bench
